/* File: verification/timestamp_modulo_event_timer_test.sv */
`timescale 1ns/1ps
`include "timer_regs.svh"
module timestamp_modulo_event_timer_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic trigger;
    logic [15:0] n_trig;
    logic wide;
    int n_errors = 0;
    int checked = 0;
    logic [31:0] seed = 32'h41d7fbe4;
    logic [31:0] v;
    logic [31:0] a;
    int ev_q[$];
    logic [7:0] regs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24};

    always #2.5 clk = ~clk;

    event_timer u_dut (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .trigger(trigger)
    );

    trig_sink u_sink (
        .clk(clk), .nrst(nrst), .trigger(trigger), .n_trig(n_trig), .wide(wide)
    );

    // ====================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // First multiple of the period strictly after the start time
    function automatic int first_at(input int s, input int p);
        return s - s % p + p;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] ad, output logic [31:0] d);
        @(posedge clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic expect_rd(input logic [7:0] ad, input logic [31:0] e);
        logic [31:0] d;
        rd_reg(ad, d);
        check(d, e);
    endtask

    // Count advance over exactly n clock cycles between two reads
    task automatic rate(input logic [7:0] ad, input int n, input logic [31:0] e);
        logic [31:0] x0;
        logic [31:0] x1;
        rd_reg(ad, x0);
        repeat (n - 2) @(posedge clk);
        rd_reg(ad, x1);
        check(x1 - x0, e);
    endtask

    // Wait for the next pulse, then compare the count it fired at
    task automatic next_event;
        logic [15:0] n0;
        logic [31:0] t;
        n0 = n_trig;
        for (int i = 0; i < 20000 && n_trig === n0; i++) begin
            @(posedge clk);
        end
        rd_reg(`REG_TS, t);
        check(t, 32'(ev_q.pop_front()));
    endtask

    task automatic stop_test;
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    // ====================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        foreach (regs[i]) begin
            expect_rd(regs[i], 32'h0000_0000);
        end
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr_reg(`REG_START, seed);
            expect_rd(`REG_START, seed);
            seed = lfsr(seed);
            wr_reg(`REG_PERIOD, seed);
            expect_rd(`REG_PERIOD, seed);
            wr_reg(`REG_FIRST, seed);
            expect_rd(`REG_FIRST, 32'h0000_0000);
        end
        rate(`REG_TS, 1000, 32'h0000_0005);
        wr_reg(`REG_CTRL, 32'h0000_0001);
        rate(`REG_TS, 80, 32'h0000_0032);
        rd_reg(`REG_NET_TS, a);
        wr_reg(`REG_CMD, 32'h0000_0001);
        rd_reg(`REG_LOCAL_TS, v);
        check(32'(v < 32'h0000_0002), 32'h0000_0001);
        rd_reg(`REG_NET_TS, v);
        check(32'(v > a), 32'h0000_0001);
        wr_reg(`REG_CTRL, 32'h0000_0000);
        wr_reg(`REG_CMD, 32'h0000_0001);
        rd_reg(`REG_NET_TS, v);
        check(32'(v < 32'h0000_0008), 32'h0000_0001);
        // Running schedule on the local source
        // start clear of boundary
        wr_reg(`REG_START, 32'h0000_0014);
        wr_reg(`REG_PERIOD, 32'h0000_000a);
        wr_reg(`REG_CMD, 32'h0000_0001);
        wr_reg(`REG_CTRL, 32'h0000_0002);
        ev_q.push_back(first_at(20, 10));
        ev_q.push_back(first_at(20, 10) + 10);
        ev_q.push_back(first_at(20, 10) + 30);
        ev_q.push_back(20);
        next_event();
        expect_rd(`REG_FIRST, 32'(first_at(20, 10)));
        next_event();
        wr_reg(`REG_PERIOD, 32'h0000_0014);
        next_event();
        wr_reg(`REG_CMD, 32'h0000_0001);
        next_event();
        expect_rd(`REG_STATUS, 32'h0000_0003);
        wr_reg(`REG_CTRL, 32'h0000_0000);
        expect_rd(`REG_STATUS, 32'h0000_0000);
        // Zero between start time and first event
        wr_reg(`REG_PERIOD, 32'h0000_000a);
        wr_reg(`REG_CMD, 32'h0000_0001);
        wr_reg(`REG_CTRL, 32'h0000_0002);
        v = 32'h0000_0000;
        for (int i = 0; i < 40 && v < 32'h0000_0019; i++) begin
            rd_reg(`REG_TS, v);
            repeat (150) @(posedge clk);
        end
        wr_reg(`REG_CMD, 32'h0000_0001);
        expect_rd(`REG_FIRST, 32'(first_at(20, 10)));
        expect_rd(`REG_STATUS, 32'h0000_0002);
        ev_q.push_back(first_at(20, 10));
        next_event();
        check(32'(n_trig), 32'h0000_0005);
        check({31'h0, wide}, 32'h0000_0000);
        stop_test();
    end
endmodule // timestamp_modulo_event_timer_test

/* File: verification/trig_sink.sv */
`timescale 1ns/1ps
module trig_sink (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Trigger from the timer
    input wire logic trigger,
    // Observations
    output logic [15:0] n_trig,
    output logic wide
);
    logic prev_r;

    // ====================
    // Acquisition side
    // one cycle pulse
    always_ff @(posedge clk) begin
        if (!nrst) begin
            n_trig <= 16'h0000;
            wide <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            prev_r <= trigger;
            if (trigger && !prev_r) begin
                n_trig <= n_trig + 16'h0001;
            end
            if (trigger && prev_r) begin
                wide <= 1'b1;
            end
        end
    end
endmodule // trig_sink

/* File: verilog/event_timer.sv */
// How it works
// RL1 - Local source: timestamp advances once every microsecond.
// RL2 - Network source: timestamp advances in 8 ns ticks.
// RL3 - Counter counts up always; zero command clears it when sync is off.
// RL4 - With sync on, zero command clears the local counter only.
// RL5 - First event at first period multiple after start time.
// RL6 - Further events every period ticks until generation stops.
// RL7 - Timestamp of the first event is stored and readable.
// RL8 - Software keeps start time clear of the next period boundary.
// RL9 - Zeroing before first event keeps the stored first event time.
// RL10 - Zeroing while running resumes at first multiple after the zero.
// RL11 - Period change applies one new period after the previous event.
// RL12 - Each event is a one cycle trigger pulse.
`timescale 1ns/1ps
`include "timer_regs.svh"
module event_timer
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Acquisition trigger
    output logic trigger
);

    main_state_t s;
    main_state_t n;

    logic local_tick;
    logic net_tick;
    logic [31:0] local_ts;
    logic [31:0] net_ts;
    logic [31:0] sel_ts;
    logic zero_cmd;
    logic net_zero;
    logic sched_zero;
    logic [31:0] next_due;
    logic fire;
    logic [32:0] trial;

    // ========================================
    // Time bases
    tick_gen u_ticks (
        .clk(clk),
        .nrst(nrst),
        .local_tick(local_tick),
        .net_tick(net_tick)
    );

    // RL3 zero command decoded from a write
    assign zero_cmd = wr && (addr == `REG_CMD) && wdata[`CMD_ZERO_BIT];
    // RL4 network count is untouched while sync mode is on
    assign net_zero = zero_cmd && !s.sync;

    // RL1 local count on the microsecond tick
    ts_counter u_local (
        .clk(clk),
        .nrst(nrst),
        .tick(local_tick),
        .zero(zero_cmd),
        .ts(local_ts)
    );

    // RL2 network count on the 8 ns tick
    ts_counter u_net (
        .clk(clk),
        .nrst(nrst),
        .tick(net_tick),
        .zero(net_zero),
        .ts(net_ts)
    );

    assign sel_ts = s.sync ? net_ts : local_ts;
    // Scheduler sees a zero only when the selected counter is actually cleared
    assign sched_zero = net_zero;

    // ========================================
    // Event comparison
    // RL11 next due time uses the live period, so a change acts on the next event
    assign next_due = s.last + s.period;
    // Greater-or-equal catches a due time passed during a late arm
    assign fire = ((s.st == S_ARMED) && (sel_ts >= s.first)) ||
        ((s.st == S_RUN) && (s.period != 32'h0) && (sel_ts >= next_due));

    // Restoring remainder step, one dividend bit per cycle
    assign trial = {s.rem, s.dvd[31]};

    // ========================================
    // Next state
    always_comb begin
        n = s;
        n.trig = 1'b0;
        n.rdata = 32'h0;

        // Register writes
        if (wr) begin
            if (addr == `REG_CTRL) begin
                n.sync = wdata[`CTRL_SYNC_BIT];
                n.en = wdata[`CTRL_EN_BIT];
            end
            if (addr == `REG_START) begin
                n.start = wdata;
            end
            if (addr == `REG_PERIOD) begin
                n.period = wdata;
            end
        end

        // Register reads, unmapped offsets answer zero
        if (rd) begin
            case (addr)
                `REG_CTRL: begin
                    n.rdata[`CTRL_SYNC_BIT] = s.sync;
                    n.rdata[`CTRL_EN_BIT] = s.en;
                end
                `REG_START: begin
                    n.rdata = s.start;
                end
                `REG_PERIOD: begin
                    n.rdata = s.period;
                end
                // RL7 first event time readable
                `REG_FIRST: begin
                    n.rdata = s.first;
                end
                `REG_TS: begin
                    n.rdata = sel_ts;
                end
                `REG_LOCAL_TS: begin
                    n.rdata = local_ts;
                end
                `REG_NET_TS: begin
                    n.rdata = net_ts;
                end
                `REG_STATUS: begin
                    n.rdata = {30'h0, s.st};
                end
                default: begin
                    n.rdata = 32'h0;
                end
            endcase
        end

        // Event scheduler
        unique case (s.st)
            S_IDLE: begin
                // A zero period would fire every tick, so it keeps the block idle
                // Start and period are copied for the divide; later starts need a new enable
                if (s.en && (s.period != 32'h0)) begin
                    n.st = S_DIV;
                    n.rem = 32'h0;
                    n.dvd = s.start;
                    n.dstart = s.start;
                    n.dper = s.period;
                    n.dcnt = 6'(`DIV_STEPS);
                end
            end
            S_DIV: begin
                if (s.dcnt != 6'h00) begin
                    if (trial >= {1'b0, s.dper}) begin
                        n.rem = 32'(trial - {1'b0, s.dper});
                    end else begin
                        n.rem = trial[31:0];
                    end
                    n.dvd = {s.dvd[30:0], 1'b0};
                    n.dcnt = s.dcnt - 6'h01;
                end else begin
                    // RL5 start rounded down to a multiple, plus one period
                    n.first = s.dstart - s.rem + s.dper;
                    n.st = S_ARMED;
                end
            end
            S_ARMED: begin
                // RL9 a zero here leaves the first event time alone
                if (fire) begin
                    n.trig = 1'b1;
                    // RL7 record the time the first event really left
                    n.first = sel_ts;
                    n.last = sel_ts;
                    n.st = S_RUN;
                end
            end
            S_RUN: begin
                // A due time that wraps past the top of the count fires at once
                // RL6 one event per period
                if (fire) begin
                    n.trig = 1'b1;
                    n.last = sel_ts;
                end
                // RL10 rebase on zero so events fall on multiples from zero
                if (sched_zero) begin
                    n.last = 32'h0;
                end
            end
        endcase

        // RL6 clearing the enable stops generation
        if (!s.en) begin
            n.st = S_IDLE;
        end
    end

    // ========================================
    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
            s.sync <= 1'(`CTRL_RST >> `CTRL_SYNC_BIT);
            s.en <= 1'(`CTRL_RST >> `CTRL_EN_BIT);
            s.start <= `START_RST;
            s.period <= `PERIOD_RST;
        end else begin
            s <= n;
        end
    end

    assign rdata = s.rdata;
    // RL12 trigger straight from the pulse flop
    assign trigger = s.trig;

    // ========================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // RL3 zero clears both
    a_zero_both: assert property ( // RL3
        zero_cmd && !s.sync |=> local_ts == 32'h0 && net_ts == 32'h0)
        else $error("zero command missed a counter");

    // RL4 network count kept
    a_zero_local_only: assert property ( // RL4
        zero_cmd && s.sync |=> local_ts == 32'h0 && (net_ts - $past(net_ts)) <= 32'h1)
        else $error("network count disturbed in sync mode");

    // RL5 next period multiple
    a_first_aligned: assert property ( // RL5
        s.st == S_ARMED && $past(s.st) == S_DIV |->
            (s.first % s.dper) == 32'h0 && s.first > s.dstart &&
            (s.first - s.dstart) <= s.dper)
        else $error("first event time not next multiple");

    // RL7 first time recorded
    a_first_recorded: assert property ( // RL7
        s.st == S_ARMED && fire |=> s.trig && s.first == $past(sel_ts) && s.st != S_DIV)
        else $error("first event time not recorded");

    // RL9 first time kept
    a_first_kept: assert property ( // RL9
        s.st == S_ARMED && sched_zero && !fire && s.en |=>
            s.st == S_ARMED && $stable(s.first))
        else $error("first event time lost on zero");

    // RL10 rebase on zero
    a_run_rebase: assert property ( // RL10
        s.st == S_RUN && sched_zero |=> s.last == 32'h0)
        else $error("schedule not rebased after zero");

    // RL6 periodic event raised
    a_run_event: assert property ( // RL6
        s.st == S_RUN && s.en && fire && !sched_zero |=>
            s.trig && s.last == $past(sel_ts))
        else $error("periodic event missed");

    // RL11 no early event
    a_no_early: assert property ( // RL11
        s.st == S_RUN && s.period != 32'h0 && sel_ts < s.last + s.period |=> !s.trig)
        else $error("event before one period elapsed");

    // RL6 stop ends events
    a_stop: assert property ( // RL6
        !s.en |=> ##1 !s.trig [*2])
        else $error("event after generation stopped");

    // RL12 single cycle pulse
    a_trig_single: assert property ( // RL12
        s.trig |-> ($past(s.st) == S_ARMED || $past(s.st) == S_RUN) ##1 !s.trig)
        else $error("trigger not a single pulse");

    // ========================================
    // Register, scheduler and network counter checks

    // RL7 first time readable
    a_first_read: assert property ( // RL7
        rd && addr == `REG_FIRST |=> rdata == $past(s.first))
        else $error("first event time not returned");

    // RL3 count readable
    a_ts_read: assert property ( // RL3
        rd && addr == `REG_TS |=> rdata == $past(sel_ts))
        else $error("timestamp not returned");

    // RL6 idle is quiet
    a_idle_quiet: assert property ( // RL6
        s.st == S_IDLE |=> !s.trig)
        else $error("event while idle");

    // RL6 zero period idles
    a_zero_period: assert property ( // RL6
        s.st == S_IDLE && s.period == 32'h0 |=> s.st == S_IDLE)
        else $error("armed with zero period");

    // RL5 arm loads divide
    a_arm_load: assert property ( // RL5
        s.st == S_IDLE && s.en && s.period != 32'h0 |=> s.st == S_DIV &&
            s.dstart == $past(s.start) && s.dper == $past(s.period) && s.dcnt == `DIV_STEPS)
        else $error("divide not loaded on arm");

    // RL5 divide steps down
    a_div_steps: assert property ( // RL5
        s.st == S_DIV && s.dcnt != 6'h00 && s.en |=>
            s.st == S_DIV && s.dcnt == $past(s.dcnt) - 6'h01)
        else $error("divide step skipped");

    // RL5 divide then armed
    a_div_done: assert property ( // RL5
        s.st == S_DIV && s.dcnt == 6'h00 && s.en |=> s.st == S_ARMED)
        else $error("divide did not arm");

    // RL5 no early first
    a_armed_quiet: assert property ( // RL5
        s.st == S_ARMED && sel_ts < s.first |=> !s.trig)
        else $error("first event before its time");

    // RL9 armed time fixed
    a_first_fixed: assert property ( // RL9
        s.st == S_ARMED && !fire |=> $stable(s.first))
        else $error("first event time moved while armed");

    // RL6 stop returns idle
    a_stop_idle: assert property ( // RL6
        !s.en |=> s.st == S_IDLE)
        else $error("scheduler still busy after stop");

    // RL4 network count free
    a_net_free: assert property ( // RL4
        s.sync |=> (net_ts - $past(net_ts)) <= 32'h1)
        else $error("network count jumped in sync mode");

endmodule // event_timer

/* File: verilog/tick_gen.sv */
`timescale 1ns/1ps
`include "timer_regs.svh"
module tick_gen
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Tick enables
    output logic local_tick,
    output logic net_tick
);

    tick_state_t s;
    tick_state_t n;
    logic [4:0] sum;

    localparam logic [7:0] LOC_LAST = 8'(`LOCAL_TICK_CYC - 1);

    // ========================================
    // Tick generation
    always_comb begin
        n = s;
        sum = 5'(s.acc) + 5'(`CLK_NS);
        // RL1 microsecond divider
        n.loc = (s.cnt == LOC_LAST);
        n.cnt = (s.cnt == LOC_LAST) ? 8'h00 : s.cnt + 8'h01;
        // RL2 fractional 8 ns ticks, exact on average since 8 ns is not whole cycles
        if (sum >= 5'(`NET_TICK_NS)) begin
            n.acc = 4'(sum - 5'(`NET_TICK_NS));
            n.net = 1'b1;
        end else begin
            n.acc = 4'(sum);
            n.net = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign local_tick = s.loc;
    assign net_tick = s.net;

    // ========================================
    // Checks
    logic [7:0] gap;
    logic seen;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            gap <= 8'h00;
            seen <= 1'b0;
        end else if (s.loc) begin
            gap <= 8'h00;
            seen <= 1'b1;
        end else begin
            gap <= gap + 8'h01;
        end
    end

    // RL1 microsecond spacing
    a_local_rate: assert property ( // RL1
        @(posedge clk) disable iff (!nrst) s.loc && seen |-> gap == 8'hc7)
        else $error("local tick spacing wrong");

    // RL2 no long gap
    a_net_no_gap: assert property ( // RL2
        @(posedge clk) disable iff (!nrst) $past(nrst) && !s.net |=> s.net)
        else $error("network tick gap too long");

    // RL2 no dense run
    a_net_no_run: assert property ( // RL2
        @(posedge clk) disable iff (!nrst) s.net [*2] |=> !s.net)
        else $error("network ticks too dense");

endmodule // tick_gen

/* File: verilog/timer_pkg.sv */
package timer_pkg;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_DIV = 2'b01,
        S_ARMED = 2'b10,
        S_RUN = 2'b11
    } sched_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic [3:0] acc;
        logic loc;
        logic net;
    } tick_state_t;

    typedef struct packed {
        logic [31:0] ts;
    } ctr_state_t;

    typedef struct packed {
        logic sync;
        logic en;
        logic [31:0] start;
        logic [31:0] period;
        logic [31:0] first;
        logic [31:0] last;
        logic [31:0] rem;
        logic [31:0] dvd;
        logic [31:0] dstart;
        logic [31:0] dper;
        logic [5:0] dcnt;
        sched_t st;
        logic trig;
        logic [31:0] rdata;
    } main_state_t;

endpackage

/* File: verilog/timer_regs.svh */
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ========================================
// Register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_START 8'h08
`define REG_PERIOD 8'h0c
`define REG_FIRST 8'h10
`define REG_TS 8'h14
`define REG_LOCAL_TS 8'h18
`define REG_NET_TS 8'h1c
`define REG_STATUS 8'h20

// ========================================
// Field positions
`define CTRL_SYNC_BIT 0
`define CTRL_EN_BIT 1
`define CMD_ZERO_BIT 0

// ========================================
// Reset values
`define CTRL_RST 2'h0
`define START_RST 32'h0000_0000
`define PERIOD_RST 32'h0000_0000

// ========================================
// Timing
`define CLK_MHZ 200
`define CLK_NS 5
`define LOCAL_TICK_US 1
`define LOCAL_TICK_CYC (`LOCAL_TICK_US * `CLK_MHZ)
`define NET_TICK_NS 8
`define DIV_STEPS 32

`endif

/* File: verilog/ts_counter.sv */
`timescale 1ns/1ps
module ts_counter
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic tick,
    input wire logic zero,
    // Count
    output logic [31:0] ts
);

    ctr_state_t s;
    ctr_state_t n;

    // ========================================
    // Counter
    always_comb begin
        n = s;
        // RL3 free running, zero wins over a tick
        if (zero) begin
            n.ts = 32'h0;
        end else if (tick) begin
            n.ts = s.ts + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign ts = s.ts;

    // RL3 counts up
    a_count_up: assert property ( // RL3
        @(posedge clk) disable iff (!nrst) tick && !zero |=> s.ts == $past(s.ts) + 32'h1)
        else $error("counter did not advance");

    // RL3 zero clears
    a_count_zero: assert property ( // RL3
        @(posedge clk) disable iff (!nrst) zero |=> s.ts == 32'h0 ##1 s.ts <= 32'h1)
        else $error("counter not cleared");

endmodule // ts_counter
